// ==== rtl/acq_ctrl.sv ====
// Behaviour
// - Two interrupt lines, sources chosen in interrupt select register.
// - Source select bit 0: end of conversion when 0, FIFO half full when 1.
// - Second interrupt line carries timer events only.
// - FIFO disable bit: 0 enables, 1 disables, 0 after reset.
// - Writing disable bit 0,1,0 empties the FIFO.
// - Input config bit read-only, shows jumper: 1 single-ended, 0 differential.
// - Interrupt select register reads back the last written settings.
// - Any write to software trigger location gives one conversion pulse.
// - Writes to the clear locations clear the matching interrupt flag unless it is set in the same cycle.
// - Timer window: three counters at 20h,22h,24h, control byte at 26h.
// - Conversion starts on rising edge of the chosen trigger.
// - Auto-scan off: channel register selects the channel.
// - Auto-scan on: channel steps 0 to last, one per trigger edge.
// - After last channel, scan wraps to zero until auto-scan cleared.
// - 32 single-ended or 16 differential channels by input config.
// - One 4-level gain setting applies to all channels.
// - Channel number is 5 LSBs; read returns the written setting.
// - Gain field two bits, 00 lowest to 11 highest.
`timescale 1ns/100ps
`default_nettype none
module acq_ctrl
  import acq_ctrl_pkg::*;
(
  input  wire logic                   ref_clk,
  input  wire logic                   rst,
  input  wire logic [7:0]             io_addr,
  input  wire logic                   io_wr_en,
  input  wire logic                   io_rd_en,
  input  wire logic [BUS_W-1:0]       io_wdata,
  output logic      [BUS_W-1:0]       io_rdata,
  output logic                        io_rd_valid,
  input  wire logic                   input_type_jumper,
  input  wire logic                   eoc_in,
  input  wire logic                   fifo_half_full_in,
  input  wire logic [FIFO_STAT_W-1:0] fifo_status_in,
  input  wire logic                   timer_irq_in,
  input  wire logic                   pacer_in,
  input  wire logic [TMR_W-1:0]       tmr_rdata,
  output logic                        tmr_rd,
  output logic [1:0]                  tmr_rd_addr,
  output logic                        tmr_wr,
  output logic [1:0]                  tmr_wr_addr,
  output logic [TMR_W-1:0]            tmr_wdata,
  output logic                        conv_start,
  output logic [CHAN_W-1:0]           mux_channel,
  output logic [GAIN_W-1:0]           gain_select,
  output logic                        fifo_enable,
  output logic                        fifo_flush,
  output logic                        irq1,
  output logic                        irq2
);

  typedef struct packed {
    logic [CHAN_W-1:0] chan;
    logic [GAIN_W-1:0] gain;
    logic [MODE_W-1:0] mode;
    logic [ISEL_W-1:0] isel;
    logic              irq1;
    logic              irq2;
    logic              conv;
    logic              flush;
    logic              pacer_d;
    logic              eoc_d;
    logic              hf_d;
    logic              tmr_d;
    logic [BUS_W-1:0]  rdata;
    logic              rvalid;
    logic              tmr_wr;
    logic [1:0]        tmr_idx;
    logic [TMR_W-1:0]  tmr_wdata;
  } ctrl_t;

  ctrl_t st_r;
  ctrl_t st_nxt;

  scan_if sif ();

  logic wr_chan;
  logic wr_gain;
  logic wr_mode;
  logic wr_isel;
  logic wr_soft;
  logic wr_clr1;
  logic wr_clr2;
  logic tmr_hit;
  logic eoc_rise;
  logic hf_rise;
  logic tmr_rise;
  logic pacer_rise;
  logic irq1_set;
  logic irq2_set;
  logic trig_now;

  // Address decode
  assign wr_chan = io_wr_en && io_addr == CHAN_CTRL_OFS;
  assign wr_gain = io_wr_en && io_addr == GAIN_CTRL_OFS;
  assign wr_mode = io_wr_en && io_addr == TRIG_MODE_OFS;
  assign wr_isel = io_wr_en && io_addr == IRQ_SEL_OFS;
  assign wr_soft = io_wr_en && io_addr == SOFT_TRIG_OFS;
  assign wr_clr1 = io_wr_en && io_addr == IRQ1_CLR_OFS;
  assign wr_clr2 = io_wr_en && io_addr == IRQ2_CLR_OFS;
  assign tmr_hit = io_addr == TMR_CNT0_OFS || io_addr == TMR_CNT1_OFS
                || io_addr == TMR_CNT2_OFS || io_addr == TMR_CTRL_OFS;

  // Edge detection of event inputs
  assign eoc_rise   = eoc_in && !st_r.eoc_d;
  assign hf_rise    = fifo_half_full_in && !st_r.hf_d;
  assign tmr_rise   = timer_irq_in && !st_r.tmr_d;
  assign pacer_rise = pacer_in && !st_r.pacer_d;

  // Interrupt sources
  assign irq1_set = st_r.isel[SRC0_SEL_BIT] ? hf_rise : eoc_rise;
  assign irq2_set = st_r.isel[SRC1_SEL_BIT] && tmr_rise;

  // Trigger: software write, or pacer rising edge when selected
  assign trig_now = wr_soft || (st_r.mode[PACER_SEL_BIT] && pacer_rise);

  always_comb begin
    st_nxt         = st_r;
    st_nxt.eoc_d   = eoc_in;
    st_nxt.hf_d    = fifo_half_full_in;
    st_nxt.tmr_d   = timer_irq_in;
    st_nxt.pacer_d = pacer_in;
    st_nxt.conv    = trig_now;
    st_nxt.flush   = 1'b0;
    st_nxt.rvalid  = io_rd_en;
    st_nxt.tmr_wr  = io_wr_en && tmr_hit;

    if (io_wr_en && tmr_hit) begin
      st_nxt.tmr_idx   = io_addr[2:1];
      st_nxt.tmr_wdata = io_wdata[TMR_W-1:0];
    end

    if (wr_chan) begin
      st_nxt.chan = io_wdata[CHAN_W-1:0];
    end
    if (wr_gain) begin
      st_nxt.gain = io_wdata[GAIN_W-1:0];
    end
    if (wr_mode) begin
      st_nxt.mode = io_wdata[MODE_W-1:0];
    end
    if (wr_isel) begin
      st_nxt.isel = io_wdata[ISEL_W-1:0];
      st_nxt.flush = io_wdata[FIFO_DIS_BIT] && !st_r.isel[FIFO_DIS_BIT];
    end

    // Set wins over a clear in the same cycle
    if (irq1_set) begin
      st_nxt.irq1 = 1'b1;
    end else if (wr_clr1) begin
      st_nxt.irq1 = 1'b0;
    end
    if (irq2_set) begin
      st_nxt.irq2 = 1'b1;
    end else if (wr_clr2) begin
      st_nxt.irq2 = 1'b0;
    end

    // Read mux, unmapped and write-only locations read zero
    st_nxt.rdata = '0;
    if (io_rd_en) begin
      unique case (io_addr)
        CHAN_CTRL_OFS: st_nxt.rdata[CHAN_W-1:0] = st_r.chan;
        GAIN_CTRL_OFS: st_nxt.rdata[GAIN_W-1:0] = st_r.gain;
        TRIG_MODE_OFS: st_nxt.rdata[MODE_W-1:0] = st_r.mode;
        IRQ_SEL_OFS: begin
          st_nxt.rdata[ISEL_W-1:0] = st_r.isel;
          st_nxt.rdata[IN_CFG_BIT] = input_type_jumper;
        end
        SOFT_TRIG_OFS: st_nxt.rdata[FIFO_STAT_W-1:0] = fifo_status_in;
        TMR_CNT0_OFS,
        TMR_CNT1_OFS,
        TMR_CNT2_OFS: st_nxt.rdata[TMR_W-1:0] = tmr_rdata;
        default: st_nxt.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st_r      <= '0;
      st_r.chan <= CHAN_RST;
      st_r.gain <= GAIN_RST;
      st_r.mode <= MODE_RST;
      st_r.isel <= ISEL_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Scan sequencer, steps one cycle after the trigger pulse
  assign sif.auto_scan_on = st_r.mode[AUTO_SCAN_BIT];
  assign sif.last_chan    = input_type_jumper ? st_r.chan
                                              : (st_r.chan & DIFF_CHAN_MASK);
  assign sif.step         = st_r.conv;

  chan_scan_seq u_seq (
    .ref_clk (ref_clk),
    .rst     (rst),
    .sif     (sif)
  );

  // Outputs
  assign io_rdata    = st_r.rdata;
  assign io_rd_valid = st_r.rvalid;
  assign tmr_rd      = io_rd_en && tmr_hit && io_addr != TMR_CTRL_OFS;
  assign tmr_rd_addr = io_addr[2:1];
  assign tmr_wr      = st_r.tmr_wr;
  assign tmr_wr_addr = st_r.tmr_idx;
  assign tmr_wdata   = st_r.tmr_wdata;
  assign conv_start  = st_r.conv;
  assign mux_channel = sif.chan_out;
  assign gain_select = st_r.gain;
  assign fifo_enable = !st_r.isel[FIFO_DIS_BIT];
  assign fifo_flush  = st_r.flush;
  assign irq1        = st_r.irq1;
  assign irq2        = st_r.irq2;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  property p_soft_trig;
    wr_soft |=> conv_start ##1 !conv_start || $past(trig_now);
  endproperty
  a_soft_trig: assert property (p_soft_trig) else $error("no trigger pulse");

  property p_pacer_trig;
    (pacer_rise && st_r.mode[PACER_SEL_BIT]) |=> conv_start;
  endproperty
  a_pacer_trig: assert property (p_pacer_trig) else $error("pacer edge lost");

  property p_irq1_eoc;
    (!st_r.isel[SRC0_SEL_BIT] && eoc_in && !st_r.eoc_d) |=> irq1;
  endproperty
  a_irq1_eoc: assert property (p_irq1_eoc) else $error("eoc irq missing");

  property p_irq1_hf;
    (st_r.isel[SRC0_SEL_BIT] && fifo_half_full_in && !st_r.hf_d) |=> irq1;
  endproperty
  a_irq1_hf: assert property (p_irq1_hf) else $error("half full irq missing");

  property p_irq2_timer;
    $rose(irq2) |-> $past(timer_irq_in) && $past(st_r.isel[SRC1_SEL_BIT]);
  endproperty
  a_irq2_timer: assert property (p_irq2_timer) else $error("irq2 not from timer");

  property p_irq1_clear;
    (wr_clr1 && !irq1_set) |=> !irq1;
  endproperty
  a_irq1_clear: assert property (p_irq1_clear) else $error("irq1 not cleared");

  property p_irq_hold;
    (irq1 && !wr_clr1) |=> irq1;
  endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("irq1 dropped");

  property p_fifo_flush;
    (wr_isel && io_wdata[FIFO_DIS_BIT] && fifo_enable) |=> fifo_flush && !fifo_enable;
  endproperty
  a_fifo_flush: assert property (p_fifo_flush) else $error("fifo not flushed");

  property p_jumper_read;
    (io_rd_en && io_addr == IRQ_SEL_OFS)
      |=> io_rd_valid && io_rdata[IN_CFG_BIT] == $past(input_type_jumper);
  endproperty
  a_jumper_read: assert property (p_jumper_read) else $error("jumper bit wrong");

  property p_chan_read;
    (io_rd_en && io_addr == CHAN_CTRL_OFS && !wr_chan) |=> io_rdata[4:0] == $past(st_r.chan);
  endproperty
  a_chan_read: assert property (p_chan_read) else $error("channel readback wrong");

  property p_diff_range;
    !input_type_jumper |-> mux_channel < 5'h10;
  endproperty
  a_diff_range: assert property (p_diff_range) else $error("channel out of range");

  property p_irq2_clear;
    (wr_clr2 && !irq2_set) |=> !irq2;
  endproperty
  a_irq2_clear: assert property (p_irq2_clear) else $error("irq2 not cleared");

  property p_irq2_hold;
    (irq2 && !wr_clr2) |=> irq2;
  endproperty
  a_irq2_hold: assert property (p_irq2_hold) else $error("irq2 dropped");

  property p_irq2_refused;
    (!st_r.isel[SRC1_SEL_BIT] && !irq2) |=> !irq2;
  endproperty
  a_irq2_refused: assert property (p_irq2_refused) else $error("irq2 set while off");

  property p_irq1_cause;
    $rose(irq1) |-> ($past(st_r.isel[SRC0_SEL_BIT]) ? $past(fifo_half_full_in)
                                                    : $past(eoc_in));
  endproperty
  a_irq1_cause: assert property (p_irq1_cause) else $error("irq1 from wrong source");

  property p_conv_cause;
    conv_start |-> $past(wr_soft) || $past(pacer_rise && st_r.mode[PACER_SEL_BIT]);
  endproperty
  a_conv_cause: assert property (p_conv_cause) else $error("stray conversion start");

  property p_rd_valid;
    io_rd_valid |-> $past(io_rd_en);
  endproperty
  a_rd_valid: assert property (p_rd_valid) else $error("stray read answer");

  property p_isel_read;
    (io_rd_en && io_addr == IRQ_SEL_OFS) |=> io_rdata[ISEL_W-1:0] == $past(st_r.isel);
  endproperty
  a_isel_read: assert property (p_isel_read) else $error("select readback wrong");

  property p_fifo_on;
    (wr_isel && !io_wdata[FIFO_DIS_BIT]) |=> fifo_enable && !fifo_flush;
  endproperty
  a_fifo_on: assert property (p_fifo_on) else $error("fifo not enabled");

  property p_tmr_ctrl_wr;
    (io_wr_en && io_addr == TMR_CTRL_OFS)
      |=> tmr_wr && tmr_wr_addr == 2'h3 && tmr_wdata == $past(io_wdata[TMR_W-1:0]);
  endproperty
  a_tmr_ctrl_wr: assert property (p_tmr_ctrl_wr) else $error("timer control lost");

  property p_tmr_ctrl_rd;
    (io_rd_en && io_addr == TMR_CTRL_OFS) |-> !tmr_rd ##1 (io_rdata == 16'h0000);
  endproperty
  a_tmr_ctrl_rd: assert property (p_tmr_ctrl_rd) else $error("control byte read");

  property p_manual_chan;
    (!st_r.mode[AUTO_SCAN_BIT] && input_type_jumper) |-> mux_channel == st_r.chan;
  endproperty
  a_manual_chan: assert property (p_manual_chan) else $error("manual channel wrong");

  property p_gain_wr;
    wr_gain |=> gain_select == $past(io_wdata[GAIN_W-1:0]);
  endproperty
  a_gain_wr: assert property (p_gain_wr) else $error("gain not applied");

endmodule : acq_ctrl
`default_nettype wire

// ==== rtl/acq_ctrl_pkg.sv ====
package acq_ctrl_pkg;

  // Register offsets inside the first I/O window
  localparam logic [7:0] CHAN_CTRL_OFS  = 8'h02;
  localparam logic [7:0] GAIN_CTRL_OFS  = 8'h04;
  localparam logic [7:0] TRIG_MODE_OFS  = 8'h06;
  localparam logic [7:0] IRQ_SEL_OFS    = 8'h08;
  localparam logic [7:0] SOFT_TRIG_OFS  = 8'h0a;
  localparam logic [7:0] IRQ1_CLR_OFS   = 8'h0c;
  localparam logic [7:0] IRQ2_CLR_OFS   = 8'h0e;
  localparam logic [7:0] TMR_CNT0_OFS   = 8'h20;
  localparam logic [7:0] TMR_CNT1_OFS   = 8'h22;
  localparam logic [7:0] TMR_CNT2_OFS   = 8'h24;
  localparam logic [7:0] TMR_CTRL_OFS   = 8'h26;

  // Field widths
  localparam int CHAN_W      = 5;
  localparam int GAIN_W      = 2;
  localparam int MODE_W      = 4;
  localparam int ISEL_W      = 3;
  localparam int FIFO_STAT_W = 4;
  localparam int TMR_W       = 8;
  localparam int BUS_W       = 16;

  // Interrupt select register bit positions
  localparam int SRC0_SEL_BIT  = 0;
  localparam int SRC1_SEL_BIT  = 1;
  localparam int FIFO_DIS_BIT  = 2;
  localparam int IN_CFG_BIT    = 3;

  // Trigger mode register bit positions
  localparam int AUTO_SCAN_BIT = 0;
  localparam int PACER_SEL_BIT = 1;

  // Reset values
  localparam logic [CHAN_W-1:0] CHAN_RST = 5'h00;
  localparam logic [GAIN_W-1:0] GAIN_RST = 2'h0;
  localparam logic [MODE_W-1:0] MODE_RST = 4'h0;
  localparam logic [ISEL_W-1:0] ISEL_RST = 3'h0;

  // Channel limit in differential mode
  localparam logic [CHAN_W-1:0] DIFF_CHAN_MASK = 5'h0f;

endpackage : acq_ctrl_pkg

// ==== rtl/chan_scan_seq.sv ====
`timescale 1ns/100ps
`default_nettype none
module chan_scan_seq
  import acq_ctrl_pkg::*;
(
  input  wire logic ref_clk,
  input  wire logic rst,
  scan_if.seq       sif
);

  typedef struct packed {
    logic [CHAN_W-1:0] idx;
    logic              scan_d;
  } seq_t;

  seq_t st_r;
  seq_t st_nxt;

  always_comb begin
    st_nxt        = st_r;
    st_nxt.scan_d = sif.auto_scan_on;
    if (!sif.auto_scan_on || !st_r.scan_d) begin
      st_nxt.idx = CHAN_RST;
    end else if (sif.step) begin
      if (st_r.idx >= sif.last_chan) begin
        st_nxt.idx = CHAN_RST;
      end else begin
        st_nxt.idx = st_r.idx + 5'h01;
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Manual mode follows the register, scan mode the counter
  assign sif.chan_out = sif.auto_scan_on ? st_r.idx : sif.last_chan;

  property p_scan_wrap;
    @(posedge ref_clk) disable iff (rst)
    (sif.auto_scan_on && st_r.scan_d && sif.step && sif.chan_out == sif.last_chan)
      |=> (!sif.auto_scan_on || sif.chan_out == 5'h00);
  endproperty
  a_scan_wrap: assert property (p_scan_wrap) else $error("scan did not wrap");

  property p_scan_step;
    @(posedge ref_clk) disable iff (rst)
    (sif.auto_scan_on && st_r.scan_d && sif.step && sif.chan_out < sif.last_chan)
      |=> (!sif.auto_scan_on || sif.chan_out == $past(sif.chan_out) + 5'h01);
  endproperty
  a_scan_step: assert property (p_scan_step) else $error("scan did not step");

  property p_scan_start;
    @(posedge ref_clk) disable iff (rst)
    $rose(sif.auto_scan_on) |-> ##1 (!sif.auto_scan_on || sif.chan_out == 5'h00);
  endproperty
  a_scan_start: assert property (p_scan_start) else $error("scan not at zero");

endmodule : chan_scan_seq
`default_nettype wire

// ==== rtl/scan_if.sv ====
`timescale 1ns/100ps
`default_nettype none
interface scan_if;
  logic       auto_scan_on;
  logic [4:0] last_chan;
  logic       step;
  logic [4:0] chan_out;

  modport ctrl (output auto_scan_on, output last_chan, output step, input chan_out);
  modport seq  (input auto_scan_on, input last_chan, input step, output chan_out);
endinterface : scan_if
`default_nettype wire

// ==== tb/host_io_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module host_io_model
  import acq_ctrl_pkg::*;
(
  input  wire logic             ref_clk,
  output logic      [7:0]       io_addr,
  output logic                  io_wr_en,
  output logic                  io_rd_en,
  output logic      [BUS_W-1:0] io_wdata,
  input  wire logic [BUS_W-1:0] io_rdata,
  input  wire logic             io_rd_valid
);
  initial begin
    io_addr  = 8'h00;
    io_wr_en = 1'b0;
    io_rd_en = 1'b0;
    io_wdata = 16'h0000;
  end
  // Idle bus shows inverted values, never the last word
  task automatic wr(input logic [7:0] a, input logic [BUS_W-1:0] d);
    @(negedge ref_clk);
    io_addr  = a;
    io_wdata = d;
    io_wr_en = 1'b1;
    @(negedge ref_clk);
    io_wr_en = 1'b0;
    io_addr  = ~a;
    io_wdata = ~d;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [BUS_W-1:0] d, output logic v);
    @(negedge ref_clk);
    io_addr  = a;
    io_rd_en = 1'b1;
    @(negedge ref_clk);
    io_rd_en = 1'b0;
    io_addr  = ~a;
    d        = io_rdata;
    v        = io_rd_valid;
  endtask : rd
  // Empty the sample FIFO, selects left at zero
  task automatic fifo_reset;
    for (int i = 0; i < 3; i++) begin
      wr(IRQ_SEL_OFS, {13'h0000, (i == 1), 2'b00});
    end
  endtask : fifo_reset
  task automatic clear_irq(input logic second);
    wr(second ? IRQ2_CLR_OFS : IRQ1_CLR_OFS, ~io_wdata);
  endtask : clear_irq
endmodule : host_io_model
`default_nettype wire

// ==== tb/testbench.sv ====
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import acq_ctrl_pkg::*;
  logic                   ref_clk, rst, io_wr_en, io_rd_en, io_rd_valid, input_type_jumper;
  logic                   eoc_in, fifo_half_full_in, timer_irq_in, pacer_in, tmr_rd, tmr_wr;
  logic                   conv_start, fifo_enable, fifo_flush, irq1, irq2, rval;
  logic [7:0]             io_addr, tmr_rdata, tmr_wdata;
  logic [1:0]             tmr_rd_addr, tmr_wr_addr, gain_select;
  logic [BUS_W-1:0]       io_wdata, io_rdata, rdat, v;
  logic [FIFO_STAT_W-1:0] fifo_status_in;
  logic [CHAN_W-1:0]      mux_channel, last;
  logic [2:0]             tmr_seen;
  int unsigned            miscompares = 0, n_checks = 0, flushes = 0, starts = 0, seed, n;

  acq_ctrl u_acq_ctrl (
    .ref_clk, .rst, .io_addr, .io_wr_en, .io_rd_en, .io_wdata, .io_rdata, .io_rd_valid,
    .input_type_jumper, .eoc_in, .fifo_half_full_in, .fifo_status_in, .timer_irq_in,
    .pacer_in, .tmr_rdata, .tmr_rd, .tmr_rd_addr, .tmr_wr, .tmr_wr_addr, .tmr_wdata,
    .conv_start, .mux_channel, .gain_select, .fifo_enable, .fifo_flush, .irq1, .irq2
  );
  host_io_model u_host_io_model (
    .ref_clk, .io_addr, .io_wr_en, .io_rd_en, .io_wdata, .io_rdata, .io_rd_valid
  );

  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    if (fifo_flush === 1'b1) flushes++;
    if (conv_start === 1'b1) starts++;
    if (io_rd_en === 1'b1) tmr_seen <= {tmr_rd, tmr_rd_addr};
  end

  function automatic logic [4:0] scan_chan(input int i, input logic [4:0] lst, input logic se);
    int top;
    top = se ? int'(lst) : int'(lst & 5'h0f);
    return 5'(i % (top + 1));
  endfunction : scan_chan
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
    u_host_io_model.rd(a, rdat, rval);
    check("rd_valid", 16'(rval), 16'h0001);
    check("rd_data", rdat, exp);
  endtask : rd_chk
  task automatic cyc(input int k);
    repeat (k) @(negedge ref_clk);
  endtask : cyc
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : report_and_stop

  initial begin
    #3_000_000;
    miscompares++;
    report_and_stop();
  end

  initial begin
    rst = 1'b1;
    input_type_jumper = 1'b1;
    eoc_in = 1'b0;
    fifo_half_full_in = 1'b0;
    timer_irq_in = 1'b0;
    pacer_in = 1'b0;
    tmr_rdata = 8'h00;
    seed = $urandom(32'h4ba090fa);
    fifo_status_in = 4'($urandom);
    repeat (8) @(posedge ref_clk);
    @(negedge ref_clk);
    rst = 1'b0;
    check("fifo_enable", 16'(fifo_enable), 16'h0001);
    check("irq1", 16'(irq1), 16'h0000);
    check("irq2", 16'(irq2), 16'h0000);
    rd_chk(IRQ_SEL_OFS, 16'h0008);
    // Random selects, jumper flips, writes to the read-only bit
    for (int i = 0; i < 8; i++) begin
      v = 16'($urandom);
      input_type_jumper = v[15];
      u_host_io_model.wr(IRQ_SEL_OFS, v);
      check("fifo_enable", 16'(fifo_enable), 16'(!v[2]));
      rd_chk(IRQ_SEL_OFS, {12'h000, v[15], v[2:0]});
    end
    input_type_jumper = 1'b1;
    n = flushes;
    u_host_io_model.fifo_reset();
    check("flushes", 16'(flushes - n), 16'h0001);
    check("fifo_enable", 16'(fifo_enable), 16'h0001);
    for (int i = 0; i < 4; i++) begin
      u_host_io_model.wr(SOFT_TRIG_OFS, 16'($urandom));
      check("conv_start", 16'(conv_start), 16'h0001);
      cyc(1);
      check("conv_start", 16'(conv_start), 16'h0000);
    end
    rd_chk(IRQ1_CLR_OFS, 16'h0000);
    rd_chk(SOFT_TRIG_OFS, {12'h000, fifo_status_in});
    // Wrong source rises first, then the selected one
    for (int s = 0; s < 2; s++) begin
      u_host_io_model.wr(IRQ_SEL_OFS, 16'(2 + s));
      fifo_half_full_in = (s == 0);
      eoc_in = (s == 1);
      cyc(3);
      check("irq1", 16'(irq1), 16'h0000);
      eoc_in = (s == 0);
      fifo_half_full_in = (s == 1);
      cyc(3);
      check("irq1", 16'(irq1), 16'h0001);
      eoc_in = 1'b0;
      fifo_half_full_in = 1'b0;
      cyc(6);
      check("irq1", 16'(irq1), 16'h0001);
      check("irq2", 16'(irq2), 16'h0000);
      u_host_io_model.clear_irq(1'b0);
      cyc(2);
      check("irq1", 16'(irq1), 16'h0000);
    end
    timer_irq_in = 1'b1;
    cyc(3);
    check("irq2", 16'(irq2), 16'h0001);
    check("irq1", 16'(irq1), 16'h0000);
    timer_irq_in = 1'b0;
    u_host_io_model.clear_irq(1'b1);
    cyc(2);
    check("irq2", 16'(irq2), 16'h0000);
    u_host_io_model.wr(IRQ_SEL_OFS, 16'h0000);
    timer_irq_in = 1'b1;
    cyc(3);
    check("irq2_off", 16'(irq2), 16'h0000);
    timer_irq_in = 1'b0;
    for (int k = 0; k < 4; k++) begin
      v = 16'($urandom);
      u_host_io_model.wr(TMR_CNT0_OFS + 8'(2 * k), v);
      check("tmr_wr", {tmr_wr, tmr_wr_addr, tmr_wdata}, {1'b1, 2'(k), v[7:0]});
      tmr_rdata = 8'($urandom);
      rd_chk(TMR_CNT0_OFS + 8'(2 * k), (k == 3) ? 16'h0000 : {8'h00, tmr_rdata});
      check("tmr_rd", 16'(tmr_seen), {13'h0000, k != 3, 2'(k)});
    end
    rd_chk(8'h30, 16'h0000);
    u_host_io_model.wr(TRIG_MODE_OFS, 16'h0000);
    for (int i = 0; i < 4; i++) begin
      v = 16'($urandom);
      u_host_io_model.wr(GAIN_CTRL_OFS, {v[15:2], 2'(i)});
      check("gain", 16'(gain_select), 16'(i));
      u_host_io_model.wr(CHAN_CTRL_OFS, v);
      rd_chk(CHAN_CTRL_OFS, {11'h000, v[4:0]});
      check("mux", 16'(mux_channel), {11'h000, v[4:0]});
    end
    rd_chk(GAIN_CTRL_OFS, 16'h0003);
    // Differential pass masks the last channel, then single-ended
    for (int p = 0; p < 2; p++) begin
      input_type_jumper = p[0];
      last = p ? 5'h05 : 5'h13;
      u_host_io_model.wr(CHAN_CTRL_OFS, 16'(last));
      u_host_io_model.wr(TRIG_MODE_OFS, 16'h0000);
      u_host_io_model.wr(TRIG_MODE_OFS, 16'h0001);
      cyc(1);
      check("scan_start", 16'(mux_channel), 16'h0000);
      for (int i = 0; i < 9; i++) begin
        check("scan", 16'(mux_channel), 16'(scan_chan(i, last, p[0])));
        u_host_io_model.wr(SOFT_TRIG_OFS, 16'(i));
        cyc(1);
      end
      check("scan_wrap", 16'(mux_channel), 16'(scan_chan(9, last, p[0])));
    end
    for (int m = 0; m < 2; m++) begin
      u_host_io_model.wr(TRIG_MODE_OFS, 16'(1 + 2 * m));
      n = starts;
      pacer_in = 1'b1;
      cyc(4);
      pacer_in = 1'b0;
      cyc(1);
      check("pacer", 16'(starts - n), 16'(m));
    end
    u_host_io_model.wr(TRIG_MODE_OFS, 16'h0000);
    cyc(1);
    check("scan_off", 16'(mux_channel), 16'h0005);
    report_and_stop();
  end
endmodule : testbench
`default_nettype wire
